/* src/quad_load_switch_channel_control.sv */
// register bank, serial slave and turn-on sequencing for four load switch channels
`timescale 1ns/1ps
`default_nettype none
`include "load_switch_defs.svh"

// Notes on behaviour
// - four config registers 01h-04h, wait/ramp/discharge fields
// - config resets to wait 00, ramp 011, discharge 10
// - wait code delays ramp 11/102/324/923 us
// - ramp code picks five turn-on durations
// - commanded off turns output off at once
// - control register 05h: selectors high, enables low
// - control register resets to all zero
// - power-up in pin control, outputs follow pins
module quad_load_switch_channel_control #(
    parameter logic [6:0] DEV_ADDR = 7'h5A, // arbitrary value, not tied to any part
    parameter int unsigned WAIT_CYC_2 = `WAIT_US_2 * `CLK_MHZ,
    parameter int unsigned WAIT_CYC_3 = `WAIT_US_3 * `CLK_MHZ,
    parameter int unsigned RAMP_CYC_1 = `RAMP_US_1 * `CLK_MHZ,
    parameter int unsigned RAMP_CYC_2 = `RAMP_US_2 * `CLK_MHZ,
    parameter int unsigned RAMP_CYC_3 = `RAMP_US_3 * `CLK_MHZ,
    parameter int unsigned RAMP_CYC_4 = `RAMP_US_4 * `CLK_MHZ
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic [3:0] i_channel_on_pin,
    output logic [3:0] o_channel_output,
    output logic [3:0] o_channel_ramping,
    output logic [11:0] o_ramp_code,
    output logic [7:0] o_output_discharge_level
);

    localparam int unsigned WAIT_CYC_0 = `WAIT_US_0 * `CLK_MHZ;
    localparam int unsigned WAIT_CYC_1 = `WAIT_US_1 * `CLK_MHZ;
    localparam int unsigned RAMP_CYC_0 = `RAMP_US_0 * `CLK_MHZ;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // last count of the turn-on wait for a code
    function automatic logic [15:0] wait_last(input logic [1:0] code);
        case (code)
            2'b00: wait_last = 16'(WAIT_CYC_0 - 1);
            2'b01: wait_last = 16'(WAIT_CYC_1 - 1);
            2'b10: wait_last = 16'(WAIT_CYC_2 - 1);
            default: wait_last = 16'(WAIT_CYC_3 - 1);
        endcase
    endfunction : wait_last

    // last count of the ramp; codes above 100 fall back to the slowest ramp
    function automatic logic [15:0] ramp_last(input logic [2:0] code);
        case (code)
            3'b000: ramp_last = 16'(RAMP_CYC_0 - 1);
            3'b001: ramp_last = 16'(RAMP_CYC_1 - 1);
            3'b010: ramp_last = 16'(RAMP_CYC_2 - 1);
            3'b011: ramp_last = 16'(RAMP_CYC_3 - 1);
            default: ramp_last = 16'(RAMP_CYC_4 - 1);
        endcase
    endfunction : ramp_last

    // register read mux; unmapped offsets read zero
    function automatic logic [7:0] reg_read(input load_switch_pkg::state_type s,
                                            input logic [7:0] addr);
        logic [7:0] idx;
        idx = addr - `REG_CH1_CFG;
        reg_read = 8'h00;
        if (addr >= `REG_CH1_CFG && addr <= `REG_CH4_CFG) begin
            reg_read = {1'b0, s.cfg[idx[1:0]][6:0]};
        end else if (addr == `REG_CTRL) begin
            reg_read = {s.source, s.enable};
        end
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_sync_q;
    logic rst_n;

    // async assert, release after two edges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    load_switch_pkg::state_type st_q;
    load_switch_pkg::state_type st_d;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sda_now;
    logic [3:0] req;

    always_comb begin
        st_d = st_q;
        // pins pass two flops before anything reads them
        st_d.pin_meta = i_channel_on_pin;
        st_d.pin_sync = st_q.pin_meta;
        st_d.scl_sr = {st_q.scl_sr[0], i_scl};
        st_d.sda_sr = {st_q.sda_sr[0], i_sda};
        st_d.scl_prev = st_q.scl_sr[1];
        st_d.sda_prev = st_q.sda_sr[1];
        sda_now = st_q.sda_sr[1];
        scl_rise = !st_q.scl_prev && st_q.scl_sr[1];
        scl_fall = st_q.scl_prev && !st_q.scl_sr[1];
        bus_start = st_q.scl_sr[1] && st_q.sda_prev && !sda_now;
        bus_stop = st_q.scl_sr[1] && !st_q.sda_prev && sda_now;

        // serial slave: bits shift in on scl rise, sda changes only on scl fall
        if (bus_stop) begin
            st_d.bus = load_switch_pkg::BUS_IDLE;
            st_d.sda_oe = 1'b0;
        end else if (bus_start) begin
            st_d.bus = load_switch_pkg::BUS_ADDR;
            st_d.bits = 4'h0;
            st_d.sda_oe = 1'b0;
        end else begin
            case (st_q.bus)
                load_switch_pkg::BUS_IDLE: begin
                    st_d.sda_oe = 1'b0;
                end
                load_switch_pkg::BUS_ADDR, load_switch_pkg::BUS_REG,
                load_switch_pkg::BUS_WDATA: begin
                    if (scl_rise) begin
                        st_d.shift = {st_q.shift[6:0], sda_now};
                        st_d.bits = st_q.bits + 4'h1;
                    end else if (scl_fall && st_q.bits == 4'h8) begin
                        st_d.bits = 4'h0;
                        st_d.sda_oe = 1'b1; // acknowledge
                        if (st_q.bus == load_switch_pkg::BUS_ADDR) begin
                            st_d.rw = st_q.shift[0];
                            if (st_q.shift[7:1] == DEV_ADDR) begin
                                st_d.bus = load_switch_pkg::BUS_ADDR_ACK;
                            end else begin
                                st_d.bus = load_switch_pkg::BUS_IDLE;
                                st_d.sda_oe = 1'b0;
                            end
                        end else if (st_q.bus == load_switch_pkg::BUS_REG) begin
                            st_d.ptr = st_q.shift;
                            st_d.bus = load_switch_pkg::BUS_REG_ACK;
                        end else begin
                            // writes steer config and control at any time
                            if (st_q.ptr >= `REG_CH1_CFG && st_q.ptr <= `REG_CH4_CFG) begin
                                st_d.cfg[2'(st_q.ptr - `REG_CH1_CFG)] =
                                    {1'b0, st_q.shift[6:0]};
                            end else if (st_q.ptr == `REG_CTRL) begin
                                st_d.source = st_q.shift[`CTRL_SOURCE_LSB +: 4];
                                st_d.enable = st_q.shift[`CTRL_ENABLE_LSB +: 4];
                            end
                            st_d.ptr = st_q.ptr + 8'h01;
                            st_d.bus = load_switch_pkg::BUS_WDATA_ACK;
                        end
                    end
                end
                load_switch_pkg::BUS_ADDR_ACK: begin
                    if (scl_fall) begin
                        st_d.bits = 4'h0;
                        if (st_q.rw) begin
                            st_d.shift = reg_read(st_q, st_q.ptr);
                            st_d.sda_oe = !st_d.shift[7];
                            st_d.bus = load_switch_pkg::BUS_RDATA;
                        end else begin
                            st_d.sda_oe = 1'b0;
                            st_d.bus = load_switch_pkg::BUS_REG;
                        end
                    end
                end
                load_switch_pkg::BUS_REG_ACK, load_switch_pkg::BUS_WDATA_ACK: begin
                    if (scl_fall) begin
                        st_d.sda_oe = 1'b0;
                        st_d.bus = load_switch_pkg::BUS_WDATA;
                    end
                end
                load_switch_pkg::BUS_RDATA: begin
                    if (scl_rise) begin
                        st_d.bits = st_q.bits + 4'h1;
                    end else if (scl_fall) begin
                        if (st_q.bits == 4'h8) begin
                            st_d.sda_oe = 1'b0; // let the host acknowledge
                            st_d.ptr = st_q.ptr + 8'h01;
                            st_d.bus = load_switch_pkg::BUS_RDATA_ACK;
                        end else begin
                            st_d.shift = {st_q.shift[6:0], 1'b0};
                            st_d.sda_oe = !st_q.shift[6];
                        end
                    end
                end
                load_switch_pkg::BUS_RDATA_ACK: begin
                    if (scl_rise) begin
                        st_d.bus = sda_now ? load_switch_pkg::BUS_IDLE
                                           : load_switch_pkg::BUS_RDATA_GO;
                    end
                end
                load_switch_pkg::BUS_RDATA_GO: begin
                    if (scl_fall) begin
                        st_d.bits = 4'h0;
                        st_d.shift = reg_read(st_q, st_q.ptr);
                        st_d.sda_oe = !st_d.shift[7];
                        st_d.bus = load_switch_pkg::BUS_RDATA;
                    end
                end
                default: begin
                    st_d.bus = load_switch_pkg::BUS_IDLE;
                    st_d.sda_oe = 1'b0;
                end
            endcase
        end

        // per-channel sequencing; config is sampled when a phase starts
        for (int i = 0; i < 4; i++) begin
            req[i] = st_q.source[i] ? st_q.enable[i] : st_q.pin_sync[i];
            if (!req[i]) begin
                st_d.ch[i] = load_switch_pkg::CH_OFF;
                st_d.cnt[i] = 16'h0000;
            end else begin
                case (st_q.ch[i])
                    load_switch_pkg::CH_OFF: begin
                        st_d.ch[i] = load_switch_pkg::CH_WAIT;
                        st_d.cnt[i] = wait_last(st_q.cfg[i].wait_code);
                    end
                    load_switch_pkg::CH_WAIT: begin
                        if (st_q.cnt[i] == 16'h0000) begin
                            st_d.ch[i] = load_switch_pkg::CH_RAMP;
                            st_d.cnt[i] = ramp_last(st_q.cfg[i].ramp_code);
                        end else begin
                            st_d.cnt[i] = st_q.cnt[i] - 16'h0001;
                        end
                    end
                    load_switch_pkg::CH_RAMP: begin
                        if (st_q.cnt[i] == 16'h0000) begin
                            st_d.ch[i] = load_switch_pkg::CH_ON;
                        end else begin
                            st_d.cnt[i] = st_q.cnt[i] - 16'h0001;
                        end
                    end
                    load_switch_pkg::CH_ON: begin
                        st_d.cnt[i] = 16'h0000;
                    end
                    default: begin
                        st_d.ch[i] = load_switch_pkg::CH_OFF;
                    end
                endcase
            end
            // switch conducts from ramp start; drops one cycle after the off command
            st_d.out_on[i] = st_d.ch[i] == load_switch_pkg::CH_RAMP ||
                             st_d.ch[i] == load_switch_pkg::CH_ON;
            st_d.ramping[i] = st_d.ch[i] == load_switch_pkg::CH_RAMP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.cfg <= {4{`CFG_RESET}};
            st_q.source <= 4'(`CTRL_RESET >> `CTRL_SOURCE_LSB);
            st_q.enable <= 4'(`CTRL_RESET);
            st_q.scl_sr <= 2'b11;
            st_q.sda_sr <= 2'b11;
            st_q.scl_prev <= 1'b1;
            st_q.sda_prev <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    always_comb begin
        o_sda_out = st_q.sda_out;
        o_sda_oe = st_q.sda_oe;
        o_channel_output = st_q.out_on;
        o_channel_ramping = st_q.ramping;
        for (int i = 0; i < 4; i++) begin
            o_ramp_code[i*3 +: 3] = st_q.cfg[i].ramp_code;
            o_output_discharge_level[i*2 +: 2] = st_q.cfg[i].discharge_code;
        end
    end

endmodule : quad_load_switch_channel_control
`default_nettype wire

/* src/load_switch_defs.svh */
// offsets, reset values, field positions and timing figures of the channel controller
`ifndef LOAD_SWITCH_DEFS_SVH
`define LOAD_SWITCH_DEFS_SVH

`define REG_CH1_CFG 8'h01
`define REG_CH4_CFG 8'h04
`define REG_CTRL 8'h05

`define CFG_RESET 8'h0E
`define CTRL_RESET 8'h00
`define CTRL_SOURCE_LSB 4
`define CTRL_ENABLE_LSB 0

`define CLK_MHZ 25
`define WAIT_US_0 11
`define WAIT_US_1 102
`define WAIT_US_2 324
`define WAIT_US_3 923
`define RAMP_US_0 11
`define RAMP_US_1 247
`define RAMP_US_2 416
`define RAMP_US_3 761
`define RAMP_US_4 1481

`endif

/* src/load_switch_pkg.sv */
// types shared by the channel controller
package load_switch_pkg;

    typedef enum logic [1:0] {CH_OFF, CH_WAIT, CH_RAMP, CH_ON} ch_state_type;

    typedef enum logic [3:0] {
        BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_REG, BUS_REG_ACK,
        BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK, BUS_RDATA_GO
    } bus_state_type;

    typedef struct packed {
        logic unused;
        logic [1:0] wait_code;
        logic [2:0] ramp_code;
        logic [1:0] discharge_code;
    } cfg_type;

    typedef struct packed {
        cfg_type [3:0] cfg;
        logic [3:0] source;
        logic [3:0] enable;
        ch_state_type [3:0] ch;
        logic [3:0][15:0] cnt;
        logic [3:0] pin_meta;
        logic [3:0] pin_sync;
        logic [1:0] scl_sr;
        logic [1:0] sda_sr;
        logic scl_prev;
        logic sda_prev;
        bus_state_type bus;
        logic [3:0] bits;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic sda_oe;
        logic sda_out;
        logic [3:0] out_on;
        logic [3:0] ramping;
    } state_type;

endpackage : load_switch_pkg

/* bench/i2c_host_model.sv */
// two-wire host model that reaches the channel controller registers
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] ADDR = 7'h5A // arbitrary device address
) (
    input wire logic i_clk,
    input wire logic i_sda_oe,
    output var logic o_scl,
    output logic o_sda
);
    logic sda_drv;
    // open drain line: the pull-up wins unless a party pulls low
    assign o_sda = sda_drv & ~i_sda_oe;
    initial begin
        o_scl = 1'b1;
        sda_drv = 1'b1;
    end
    // five clocks a step keeps every level above the three-clock sync need
    task automatic set_scl(input logic s);
        repeat (5) @(posedge i_clk);
        o_scl <= s;
    endtask : set_scl
    task automatic set_sda(input logic d);
        repeat (5) @(posedge i_clk);
        sda_drv <= d;
    endtask : set_sda
    // start also serves as repeated start, scl is low on entry then
    task automatic start();
        set_sda(1'b1);
        set_scl(1'b1);
        set_sda(1'b0);
        set_scl(1'b0);
    endtask : start
    task automatic stop();
        set_sda(1'b0);
        set_scl(1'b1);
        set_sda(1'b1);
    endtask : stop
    // eight bits msb first, then the acknowledge slot with the line released
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int k = 7; k >= 0; k--) begin
            set_sda(tx[k]);
            set_scl(1'b1);
            rx[k] = o_sda;
            set_scl(1'b0);
        end
        set_sda(1'b1);
        set_scl(1'b1);
        ack = ~o_sda;
        set_scl(1'b0);
    endtask : xfer
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic k0, k1, k2;
        start();
        xfer({ADDR, 1'b0}, rx, k0);
        xfer(a, rx, k1);
        xfer(d, rx, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask : write_reg
    // single byte read, ended by a not-acknowledge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic k0, k1, k2, k3;
        start();
        xfer({ADDR, 1'b0}, rx, k0);
        xfer(a, rx, k1);
        start();
        xfer({ADDR, 1'b1}, rx, k2);
        xfer(8'hFF, d, k3);
        stop();
        ok = k0 & k1 & k2;
    endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

/* bench/quad_load_switch_channel_control_sva.sv */
// port assertions for the quad load switch channel controller
`timescale 1ns/1ps
`default_nettype none
module quad_load_switch_channel_control_sva (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic [3:0] i_channel_on_pin,
    input wire logic [3:0] o_channel_output,
    input wire logic [3:0] o_channel_ramping,
    input wire logic [11:0] o_ramp_code,
    input wire logic [7:0] o_output_discharge_level
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // no ramp or wait is shorter than eight cycles
    sequence ramp_run;
        o_channel_ramping[0] [*8];
    endsequence
    sequence stay_off;
        !o_channel_output[0] [*8];
    endsequence
    chk_reset_cfg: assert property ($rose(i_rst_n) |->
        o_ramp_code == 12'h6DB && o_output_discharge_level == 8'hAA)
        else $error("config outputs not at reset value");
    chk_reset_off: assert property ($rose(i_rst_n) |-> o_channel_output == 4'h0)
        else $error("channel on out of reset");
    chk_ramp_out: assert property ((o_channel_ramping & ~o_channel_output) == 4'h0)
        else $error("ramping while output off");
    chk_rise_ramp: assert property ((o_channel_output & ~$past(o_channel_output)
        & ~o_channel_ramping) == 4'h0) else $error("output rose without ramp");
    chk_ramp_min: assert property ($rose(o_channel_ramping[0]) |-> ramp_run)
        else $error("ramp too short");
    chk_off_hold: assert property ($fell(o_channel_output[0]) |-> stay_off)
        else $error("output back on too soon");
    chk_cfg_write: assert property ($changed(o_ramp_code) |-> o_sda_oe)
        else $error("ramp code moved without a bus write");
    chk_disc_write: assert property ($changed(o_output_discharge_level) |-> o_sda_oe)
        else $error("discharge code moved without a bus write");
endmodule : quad_load_switch_channel_control_sva
`default_nettype wire

/* bench/quad_load_switch_channel_control_tb.sv */
// self-checking bench for the quad load switch channel controller
`timescale 1ns/1ps
`default_nettype none
`include "load_switch_defs.svh"
module quad_load_switch_channel_control_tb;
    logic clk, rst_n, scl, sda, sda_out, sda_oe;
    logic [3:0] pin, outp, ramping;
    logic [11:0] rcode;
    logic [7:0] disc;
    int n_mismatch, cmp_count;
    // wait codes 0 to 2 and ramp code 0 keep full length, wait code 3 and ramp codes 1 to 4 are shortened by parameters
    int wait_cyc[4] = '{`WAIT_US_0 * `CLK_MHZ, `WAIT_US_1 * `CLK_MHZ,
        `WAIT_US_2 * `CLK_MHZ, 30};
    int ramp_cyc[5] = '{`RAMP_US_0 * `CLK_MHZ, 10, 20, 30, 40};
    quad_load_switch_channel_control #(.WAIT_CYC_3(30), .RAMP_CYC_1(10),
        .RAMP_CYC_2(20), .RAMP_CYC_3(30), .RAMP_CYC_4(40)) i_dut (.i_clk(clk),
        .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_channel_on_pin(pin), .o_channel_output(outp), .o_channel_ramping(ramping),
        .o_ramp_code(rcode), .o_output_discharge_level(disc));
    i2c_host_model i_host (.i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_eq(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_eq
    task automatic check_rng(input int got, input int lo, input int hi, input string what);
        cmp_count++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("wrong value at %0t: %s %0d not in %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : check_rng
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        i_host.write_reg(a, d, ok);
        check_eq(16'(ok), 16'h0001, "write ack");
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic ok;
        i_host.read_reg(a, v, ok);
        check_eq({8'h00, v}, {8'h00, exp}, "read back");
        check_eq(16'(ok), 16'h0001, "read ack");
    endtask : rchk
    // one pin-driven on/off cycle of channel one, counted on falling edges
    task automatic pin_cycle(input int w, input int r);
        int n;
        n = 0;
        pin[0] <= 1'b1;
        @(negedge clk);
        while (outp[0] !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        check_rng(n, wait_cyc[w], wait_cyc[w] + 5, "turn-on wait");
        n = 0;
        while (ramping[0] === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check_rng(n, ramp_cyc[r] - 1, ramp_cyc[r] + 1, "ramp length");
        check_eq(16'(outp[0]), 16'h0001, "on after ramp");
        @(posedge clk);
        pin[0] <= 1'b0;
        n = 0;
        while (outp[0] === 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        check_rng(n, 1, 4, "turn-off");
        @(posedge clk);
    endtask : pin_cycle
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog, about three times the expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        pin = 4'h0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check_eq({4'h0, rcode}, 16'h06DB, "ramp codes");
        check_eq(16'(sda_out), 16'h0000, "data drive level");
        check_eq({8'h00, disc}, 16'h00AA, "discharge codes");
        check_eq({12'h000, outp}, 16'h0000, "outputs");
        for (int a = 1; a <= 5; a++) rchk(8'(a), a == 5 ? 8'h00 : 8'h0E);
        rchk(8'h09, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            wreg(8'h01, {1'b0, 2'(i % 4), 3'(i), 2'b01});
            pin_cycle(i % 4, i);
        end
        check_eq({13'h0000, rcode[2:0]}, 16'h0004, "ramp field");
        check_eq({14'h0000, disc[1:0]}, 16'h0001, "discharge field");
        wreg(8'h02, 8'hFF);
        rchk(8'h02, 8'h7F);
        check_eq({13'h0000, rcode[5:3]}, 16'h0007, "ch2 ramp field");
        check_eq({14'h0000, disc[3:2]}, 16'h0003, "ch2 discharge field");
        $display("test pin timing and config done");
        wreg(8'h02, 8'h00);
        wreg(8'h05, 8'h22);
        rchk(8'h05, 8'h22);
        check_eq({12'h000, outp}, 16'h0002, "register on");
        wreg(8'h05, 8'h62);
        pin[2] <= 1'b1;
        repeat (400) @(posedge clk);
        check_eq({12'h000, outp}, 16'h0002, "pin ignored");
        wreg(8'h05, 8'h02);
        repeat (400) @(posedge clk);
        check_eq({12'h000, outp}, 16'h0004, "back to pins");
        $display("test register control done");
        wrap_up();
    end
endmodule : quad_load_switch_channel_control_tb
bind quad_load_switch_channel_control quad_load_switch_channel_control_sva i_sva (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .i_channel_on_pin(i_channel_on_pin),
    .o_channel_output(o_channel_output), .o_channel_ramping(o_channel_ramping),
    .o_ramp_code(o_ramp_code), .o_output_discharge_level(o_output_discharge_level));
`default_nettype wire
